//--- verilog/rmd_top.sv
// Resource map decoder: mapping registers, address decode and bus cycle encoding.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rmd_top (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mode strap pins {special_n, mode_b, mode_a}.
	input wire logic [2:0] mode_pins,
	// Core access request.
	input wire logic cpu_req,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_write,
	input wire logic cpu_wide,
	input wire logic bdm_active,
	input wire logic wait_mode,
	// Decoded resource.
	output rmd_pkg::rmd_sel_e res_sel,
	output logic follow_region,
	output logic port_e_local,
	output logic nvm_read_ok,
	// External bus signalling.
	output logic ext_cycle,
	output logic low_byte_strobe,
	output logic ext_rw,
	output logic ext_a0,
	output logic byte_swap,
	output logic bus_narrow,
	output logic eclk,
	output logic bus_busy,
	// Wait-mode status.
	output logic ext_bus_on,
	output logic map_iface_on
);
	import rmd_pkg::*;

	rmd_stretch_if stif ();

	logic [2:0] pins_s1_q;
	logic [2:0] pins_s2_q;
	logic [1:0] init_cnt_q;
	logic init_done_q;
	logic [2:0] mode_q;
	logic internal_cycle_visible_q;
	logic ext_bus_wait_stop_q;
	logic eme_q;
	logic mode_wr_q;
	logic [4:0] reg_pos_q;
	logic map_iface_wait_stop_q;
	logic rg_wr_q;
	logic [4:0] ram_pos_q;
	logic rm_wr_q;
	logic [3:0] nvm_pos_q;
	logic nvm_en_q;
	logic ee_wr_q;
	logic [6:0] misc_q;
	logic misc_wr_q;
	logic [21:0] map_eff_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	rmd_sel_e res_sel_q;
	logic follow_q;
	logic port_e_local_q;
	logic nvm_read_ok_q;
	logic ext_cycle_q;
	logic low_byte_strobe_q;
	logic rw_q;
	logic a0_q;
	logic swap_q;
	logic narrow_q;
	logic start_q;
	logic [1:0] extra_q;
	logic ext_on_q;
	logic map_on_q;
	logic [3:0] drain_q;

	logic special;
	logic expanded;
	logic periph;
	logic single;
	logic norm_narrow;
	logic narrow_mode;
	logic wr;
	logic wr_mode;
	logic wr_rg;
	logic wr_rm;
	logic wr_ee;
	logic wr_misc;
	logic [31:0] rd_d;
	logic miss_d;
	logic [4:0] e_reg_pos;
	logic [4:0] e_ram_pos;
	logic [3:0] e_nvm_pos;
	logic e_nvm_en;
	logic [6:0] e_misc;
	rmd_sel_e sel_d;
	logic follow_d;
	logic pe_hole;
	logic acc;
	logic is_ram;
	logic vis_d;

	// Mode decode from the latched straps.
	assign special = ~mode_q[2];
	assign expanded = mode_q[0];
	assign periph = (mode_q == MODE_PER);
	assign single = ~mode_q[0] & ~periph;
	assign norm_narrow = (mode_q == MODE_NEN);
	assign narrow_mode = expanded & ~mode_q[1];

	// Outputs.
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign res_sel = res_sel_q;
	assign follow_region = follow_q;
	assign port_e_local = port_e_local_q;
	assign nvm_read_ok = nvm_read_ok_q;
	assign ext_cycle = ext_cycle_q;
	assign low_byte_strobe = low_byte_strobe_q;
	assign ext_rw = rw_q;
	assign ext_a0 = a0_q;
	assign byte_swap = swap_q;
	assign bus_narrow = narrow_q;
	assign eclk = stif.eclk;
	assign bus_busy = stif.busy;
	assign ext_bus_on = ext_on_q;
	assign map_iface_on = map_on_q;
	assign stif.start = start_q;
	assign stif.extra = extra_q;

	rmd_stretch u_stretch (
		.pclk(pclk),
		.presetn(presetn),
		.st(stif.tim)
	);

	// Straps are pins, so they cross two flip-flops before being latched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_s1_q <= 3'h0;
			pins_s2_q <= 3'h0;
		end else begin
			pins_s1_q <= mode_pins;
			pins_s2_q <= pins_s1_q;
		end
	end

	// The mode is caught once the synchroniser has filled; the bus stays
	// unanswered until the mode-dependent reset values are loaded.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_q <= 2'h0;
			init_done_q <= 1'b0;
			mode_q <= MODE_NSC;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 2'h1;
			if (init_cnt_q == 2'h2) begin
				mode_q <= pins_s2_q;
			end
			if (init_cnt_q == 2'h3) begin
				init_done_q <= 1'b1;
			end
		end
	end

	// Writes land at the edge that completes the APB access.
	assign wr = psel & penable & pready_q & pwrite;
	assign wr_mode = wr & (paddr == ADDR_MODE) & ~periph;
	assign wr_rg = wr & (paddr == ADDR_REGBASE);
	assign wr_rm = wr & (paddr == ADDR_RAMBASE);
	assign wr_ee = wr & (paddr == ADDR_NVMBASE);
	assign wr_misc = wr & (paddr == ADDR_MISC);

	// Mode register option bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_cycle_visible_q <= 1'b0;
			ext_bus_wait_stop_q <= 1'b0;
			eme_q <= 1'b0;
			mode_wr_q <= 1'b0;
		end else if (init_cnt_q == 2'h3 && !init_done_q) begin
			internal_cycle_visible_q <= special;
			eme_q <= special;
		end else if (wr_mode) begin
			mode_wr_q <= 1'b1;
			if (special ? mode_wr_q : ~mode_wr_q) begin // R2
				internal_cycle_visible_q <= pwdata[3];
				eme_q <= pwdata[0];
			end
			if (!special) begin // R4
				ext_bus_wait_stop_q <= pwdata[2];
			end
		end
	end

	// Register block position and mapping wait-stop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_pos_q <= REG_POS_RST; // R6
			map_iface_wait_stop_q <= 1'b0;
			rg_wr_q <= 1'b0;
		end else if (wr_rg) begin
			rg_wr_q <= 1'b1;
			if (special || !rg_wr_q) begin // R7
				reg_pos_q <= pwdata[7:3];
			end
			if (!special) begin // R4
				map_iface_wait_stop_q <= pwdata[0];
			end
		end
	end

	// RAM position.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ram_pos_q <= RAM_POS_RST; // R9
			rm_wr_q <= 1'b0;
		end else if (wr_rm) begin
			rm_wr_q <= 1'b1;
			if (special || !rm_wr_q) begin // R7
				ram_pos_q <= pwdata[7:3];
			end
		end
	end

	// Nonvolatile array position and read enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_pos_q <= NVM_POS_RST;
			nvm_en_q <= 1'b1;
			ee_wr_q <= 1'b0;
		end else begin
			if (wr_ee) begin
				ee_wr_q <= 1'b1;
				if (special || !ee_wr_q) begin // R10
					nvm_pos_q <= pwdata[7:4];
				end
			end
			if (single) begin
				nvm_en_q <= 1'b1; // R12
			end else if (wr_ee) begin
				nvm_en_q <= pwdata[0]; // R12
			end
		end
	end

	// Stretch and ROM mapping control.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			misc_q <= MISC_RST_EXP;
			misc_wr_q <= 1'b0;
		end else if (init_cnt_q == 2'h3 && !init_done_q) begin
			misc_q <= single ? MISC_RST_SC : MISC_RST_EXP; // R13
		end else if (wr_misc) begin
			misc_wr_q <= 1'b1;
			if (special || !misc_wr_q) begin // R7
				misc_q <= pwdata[6:0];
			end
		end
	end

	// The decoder sees mapping changes one cycle late, which gives software the
	// documented settling slot after a write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			map_eff_q <= {REG_POS_RST, RAM_POS_RST, NVM_POS_RST, 1'b1, MISC_RST_EXP};
		end else begin
			map_eff_q <= {reg_pos_q, ram_pos_q, nvm_pos_q, nvm_en_q, misc_q}; // R24
		end
	end

	assign e_reg_pos = map_eff_q[21:17];
	assign e_ram_pos = map_eff_q[16:12];
	assign e_nvm_pos = map_eff_q[11:8];
	assign e_nvm_en = map_eff_q[7];
	assign e_misc = map_eff_q[6:0];

	// Read data and address check.
	always_comb begin
		rd_d = 32'h0;
		miss_d = 1'b0;
		if (paddr == ADDR_MODE && !periph) begin
			rd_d[7:0] = {mode_q, 1'b1, internal_cycle_visible_q, ext_bus_wait_stop_q, 1'b0, eme_q};
		end else if (paddr == ADDR_REGBASE) begin
			rd_d[7:0] = {reg_pos_q, 2'h0, map_iface_wait_stop_q};
		end else if (paddr == ADDR_RAMBASE) begin
			rd_d[7:0] = {ram_pos_q, 3'h0};
		end else if (paddr == ADDR_NVMBASE) begin
			rd_d[7:0] = {nvm_pos_q, 3'h0, nvm_en_q};
		end else if (paddr == ADDR_MISC) begin
			rd_d[7:0] = {1'b0, misc_q};
		end else begin
			miss_d = 1'b1;
		end
	end

	// APB slave: one wait state, then a single-cycle ready.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else if (init_done_q && psel && penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= miss_d;
			prdata_q <= pwrite ? 32'h0 : rd_d;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Address decode in fixed priority order.
	always_comb begin
		sel_d = SEL_NONE;
		follow_d = 1'b0;
		pe_hole = eme_q & expanded &
			(cpu_addr[8:0] == PORT_E_DATA_OFS || cpu_addr[8:0] == PORT_E_DIRECTION_OFS); // R5
		if (bdm_active && cpu_addr[15:8] == BDM_PAGE) begin
			sel_d = SEL_BDM; // R23
		end else if (cpu_addr[15:11] == e_reg_pos && cpu_addr[10:9] == REG_SEG
			&& !pe_hole) begin
			sel_d = SEL_REG; // R6
		end else if (cpu_addr[15:11] == e_ram_pos && !cpu_addr[10]) begin
			sel_d = SEL_RAM; // R9
		end else if (e_nvm_en && cpu_addr[15:12] == e_nvm_pos
			&& cpu_addr[11:8] >= NVM_FIRST_PAGE) begin
			sel_d = SEL_NVM; // R11
		end else if (e_misc[MISC_ROM_MAP_ENABLE] && cpu_addr[15] == e_misc[MISC_ROM_UPPER_HALF]) begin
			sel_d = SEL_ROM; // R18 R19
		end else if (expanded) begin
			sel_d = SEL_EXT; // R22 R25
			follow_d = (cpu_addr[15:11] == e_reg_pos) && (cpu_addr[10:9] == FOLLOW_SEG); // R15
		end
	end

	// A stopped mapping interface takes no accesses.
	assign acc = cpu_req & map_on_q & init_done_q; // R8
	assign is_ram = (sel_d == SEL_RAM);
	assign vis_d = internal_cycle_visible_q & expanded & ~norm_narrow
		& (sel_d != SEL_EXT) & (sel_d != SEL_NONE); // R1

	// Per-access select, one cycle after the request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_sel_q <= SEL_NONE;
			follow_q <= 1'b0;
		end else begin
			res_sel_q <= acc ? sel_d : SEL_NONE; // R25
			follow_q <= acc & follow_d;
		end
	end

	// External cycle encoding.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_cycle_q <= 1'b0;
			low_byte_strobe_q <= 1'b1;
			rw_q <= 1'b1;
			a0_q <= 1'b0;
			swap_q <= 1'b0;
			narrow_q <= 1'b0;
		end else if (acc) begin
			ext_cycle_q <= ext_on_q & ((sel_d == SEL_EXT) | vis_d); // R1
			// A misaligned word outside RAM is shown as its odd byte only.
			low_byte_strobe_q <= cpu_wide ? (cpu_addr[0] & is_ram) : ~cpu_addr[0]; // R20 R21
			rw_q <= ~cpu_write; // R21
			a0_q <= cpu_addr[0]; // R21
			swap_q <= cpu_wide & cpu_addr[0] & is_ram; // R20
			narrow_q <= narrow_mode | (follow_d & ~narrow_mode & e_misc[MISC_FOLLOW_REGION_NARROW]); // R14
		end else begin
			ext_cycle_q <= 1'b0;
			swap_q <= 1'b0;
		end
	end

	// Stretch start; accesses that arrive while the timer is busy are not stretched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
			extra_q <= 2'h0;
		end else begin
			start_q <= acc & ext_on_q & (sel_d == SEL_EXT) & ~stif.busy & ~start_q;
			extra_q <= follow_d ? e_misc[MISC_RFSTR+:2] : e_misc[MISC_EXSTR+:2]; // R16 R17
		end
	end

	// Wait-mode shutdown: the external bus drains before it stops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_on_q <= 1'b1;
			drain_q <= 4'h0;
			map_on_q <= 1'b1;
		end else begin
			map_on_q <= ~(wait_mode & map_iface_wait_stop_q); // R8
			if (!(wait_mode && ext_bus_wait_stop_q)) begin
				ext_on_q <= 1'b1;
				drain_q <= 4'h0;
			end else if (stif.busy || start_q || acc) begin
				// An access taken at this edge must not see the bus vanish under it.
				drain_q <= 4'h0; // R3
			end else if (drain_q >= 4'(WAIT_DRAIN_CYC)) begin
				ext_on_q <= 1'b0; // R3
			end else begin
				drain_q <= drain_q + 4'h1;
			end
		end
	end

	// Map status flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_e_local_q <= 1'b1;
			nvm_read_ok_q <= 1'b1;
		end else begin
			port_e_local_q <= ~(eme_q & expanded); // R5
			nvm_read_ok_q <= e_nvm_en; // R11
		end
	end
endmodule
`default_nettype wire

//--- verilog/rmd_pkg.sv
// Constants, encodings and types shared by the resource map decoder files.
// How it works
// R1 - Visibility bit shows internal cycles externally; ignored in normal expanded narrow mode.
// R2 - Visibility and port E emulate: write once normal, special ignores first write.
// R3 - External bus wait-stop shuts bus in wait mode after a drain delay.
// R4 - Both wait-stop bits writable anytime in normal modes, never in special modes.
// R5 - Port E emulate in expanded modes removes port E registers from the map.
// R6 - Register block resets to 0x0000; five bits place it on 2-Kbyte boundaries.
// R7 - Block, RAM and misc mapping registers: write once normal, anytime special.
// R8 - Mapping wait-stop bit shuts the mapping interface down during wait mode.
// R9 - RAM resets to 0x0800; five bits place it on 2-Kbyte boundaries.
// R10 - Nonvolatile array at 0x0D00; four position bits; once normal, anytime special.
// R11 - Nonvolatile read enable gates array reads only, never its control access.
// R12 - Nonvolatile read enable forced 1 in single-chip; writable elsewhere; 0 unmaps.
// R13 - ROM bits reset 0 expanded, 1 single-chip; external stretch resets to 11.
// R14 - Follow narrow bit makes follow region 8-bit; only in expanded wide modes.
// R15 - Follow region starts right after the register block and moves with it.
// R16 - Follow stretch code gives 0 to 3 extra E clocks; only expanded modes.
// R17 - External stretch code gives 0 to 3 extra E clocks; only expanded modes.
// R18 - ROM upper-half bit places 32-Kbyte ROM high or low; meaningless when disabled.
// R19 - ROM enable maps the ROM; debug ROM, registers, RAM, nonvolatile win over it.
// R20 - Only RAM gives strobe and A0 both high, with bytes swapped.
// R21 - Strobe, direction and A0 encode the access type and size.
// R22 - Memory expansion only exists in expanded modes.
// R23 - Fixed priority: debug ROM, registers, RAM, nonvolatile, ROM, external.
// R24 - Mapping writes take effect one cycle after the write.
// R25 - Exactly one select per access; unclaimed expanded addresses go external.
// R26 - Stretch counter holds E high for the extra periods before cycle end.
package rmd_pkg;
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned WAIT_DRAIN_NS = 160;
	localparam int unsigned WAIT_DRAIN_CYC = (WAIT_DRAIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned E_PERIOD_CYC = 2;
	localparam int unsigned E_HIGH_CYC = 1;
	localparam logic [7:0] IDX_MODE = 8'h0B;
	localparam logic [7:0] IDX_RAMBASE = 8'h10;
	localparam logic [7:0] IDX_REGBASE = 8'h11;
	localparam logic [7:0] IDX_NVMBASE = 8'h12;
	localparam logic [7:0] IDX_MISC = 8'h13;
	localparam logic [7:0] ADDR_MODE = {IDX_MODE[5:0], 2'h0};
	localparam logic [7:0] ADDR_RAMBASE = {IDX_RAMBASE[5:0], 2'h0};
	localparam logic [7:0] ADDR_REGBASE = {IDX_REGBASE[5:0], 2'h0};
	localparam logic [7:0] ADDR_NVMBASE = {IDX_NVMBASE[5:0], 2'h0};
	localparam logic [7:0] ADDR_MISC = {IDX_MISC[5:0], 2'h0};
	localparam logic [2:0] MODE_SSC = 3'h0;
	localparam logic [2:0] MODE_SEN = 3'h1;
	localparam logic [2:0] MODE_PER = 3'h2;
	localparam logic [2:0] MODE_SEW = 3'h3;
	localparam logic [2:0] MODE_NSC = 3'h4;
	localparam logic [2:0] MODE_NEN = 3'h5;
	localparam logic [2:0] MODE_NEW = 3'h7;
	localparam logic [4:0] REG_POS_RST = 5'h00;
	localparam logic [4:0] RAM_POS_RST = 5'h01;
	localparam logic [3:0] NVM_POS_RST = 4'h0;
	localparam logic [6:0] MISC_RST_EXP = 7'h0C;
	localparam logic [6:0] MISC_RST_SC = 7'h0F;
	localparam logic [1:0] REG_SEG = 2'h0;
	localparam logic [1:0] FOLLOW_SEG = 2'h1;
	localparam logic [3:0] NVM_FIRST_PAGE = 4'hD;
	localparam logic [7:0] BDM_PAGE = 8'hFF;
	localparam logic [8:0] PORT_E_DATA_OFS = 9'h008;
	localparam logic [8:0] PORT_E_DIRECTION_OFS = 9'h009;
	localparam int MISC_ROM_MAP_ENABLE = 0;
	localparam int MISC_ROM_UPPER_HALF = 1;
	localparam int MISC_EXSTR = 2;
	localparam int MISC_RFSTR = 4;
	localparam int MISC_FOLLOW_REGION_NARROW = 6;
	typedef enum logic [6:0] {
		SEL_NONE = 7'h01,
		SEL_BDM = 7'h02,
		SEL_REG = 7'h04,
		SEL_RAM = 7'h08,
		SEL_NVM = 7'h10,
		SEL_ROM = 7'h20,
		SEL_EXT = 7'h40
	} rmd_sel_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_HOLD = 2'h2
	} rmd_st_e;
endpackage

//--- verilog/rmd_stretch_if.sv
// Handshake between the decoder and the E clock stretch timer.
`timescale 1ns/100ps
`default_nettype none
interface rmd_stretch_if;
	logic start;
	logic [1:0] extra;
	logic busy;
	logic eclk;
	modport ctrl (output start, output extra, input busy, input eclk);
	modport tim (input start, input extra, output busy, output eclk);
endinterface
`default_nettype wire

//--- verilog/rmd_stretch.sv
// E clock generator with per-cycle stretch of the high phase.
`timescale 1ns/100ps
`default_nettype none
module rmd_stretch (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control from the decoder.
	rmd_stretch_if.tim st
);
	import rmd_pkg::*;

	rmd_st_e state_q;
	logic [3:0] cnt_q;
	logic eclk_q;
	logic busy_q;

	assign st.eclk = eclk_q;
	assign st.busy = busy_q;

	// Outside external cycles E runs free; a started cycle holds it high for the
	// base high time plus the extra E periods, then ends low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			eclk_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (st.start) begin
						state_q <= ST_HOLD;
						busy_q <= 1'b1;
						eclk_q <= 1'b1;
						cnt_q <= 4'(E_HIGH_CYC + st.extra * E_PERIOD_CYC); // R26
					end else begin
						eclk_q <= ~eclk_q;
					end
				end
				ST_HOLD: begin
					if (cnt_q <= 4'h1) begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
						eclk_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 4'h1; // R26
					end
				end
				default: begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- dv/rmd_properties.sv
// Concurrent checks on the resource map decoder top-level ports.
`timescale 1ns/100ps
`default_nettype none
module rmd_properties (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Core access request.
	input wire logic cpu_req,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_write,
	input wire logic cpu_wide,
	// Decode and external bus outputs.
	input wire rmd_pkg::rmd_sel_e res_sel,
	input wire logic ext_cycle,
	input wire logic low_byte_strobe,
	input wire logic ext_rw,
	input wire logic ext_a0,
	input wire logic byte_swap,
	input wire logic eclk,
	input wire logic bus_busy,
	input wire logic ext_bus_on,
	input wire logic map_iface_on
);
	import rmd_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sel_onehot_a: assert property ($onehot(res_sel))
		else $error("resource select is not one-hot");
	sel_idle_a: assert property (!$past(cpu_req) |-> res_sel == SEL_NONE)
		else $error("resource select without a request");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	pready_cause_a: assert property (pready |-> $past(psel && penable) && psel && penable)
		else $error("pready outside an access phase");
	map_stop_a: assert property ($past(cpu_req && !map_iface_on) |-> res_sel == SEL_NONE)
		else $error("access decoded while mapping interface is off");
	bus_off_a: assert property (!ext_bus_on |-> !ext_cycle)
		else $error("external cycle while external bus is shut down");
	swap_ram_a: assert property (byte_swap |-> res_sel == SEL_RAM && low_byte_strobe && ext_a0)
		else $error("byte swap outside a misaligned RAM word");
	even_word_a: assert property ($past(cpu_req && cpu_wide && !cpu_write && !cpu_addr[0])
		&& res_sel != SEL_NONE |-> !low_byte_strobe && ext_rw && !ext_a0)
		else $error("wrong encoding for an even word read");
	stretch_len_a: assert property ($rose(bus_busy) |-> ##[1:8] !bus_busy)
		else $error("stretch longer than three E clocks");
	busy_high_a: assert property (bus_busy |-> eclk)
		else $error("E clock low during a stretch");
	cover property (res_sel == SEL_EXT);
	cover property (byte_swap);
	cover property ($fell(bus_busy));
	cover property (!map_iface_on);
endmodule
bind rmd_top rmd_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
	.cpu_write(cpu_write), .cpu_wide(cpu_wide), .res_sel(res_sel), .ext_cycle(ext_cycle),
	.low_byte_strobe(low_byte_strobe), .ext_rw(ext_rw), .ext_a0(ext_a0),
	.byte_swap(byte_swap), .eclk(eclk), .bus_busy(bus_busy), .ext_bus_on(ext_bus_on),
	.map_iface_on(map_iface_on));
`default_nettype wire

//--- dv/rmd_ext_model.sv
// Far-side model of the expansion bus that times each held E high phase.
`timescale 1ns/100ps
`default_nettype none
module rmd_ext_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bus timing seen by an external memory.
	input wire logic eclk,
	input wire logic bus_busy,
	// Measurements for the bench.
	output var int hi_len,
	output var int n_ext
);
	int cnt_q;
	// A slow memory only learns the stretch when E finally falls, so count then.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			hi_len <= 0;
			n_ext <= 0;
		end else if (bus_busy && eclk) begin
			cnt_q <= cnt_q + 1;
		end else if (cnt_q != 0) begin
			hi_len <= cnt_q;
			n_ext <= n_ext + 1;
			cnt_q <= 0;
		end
	end
endmodule
`default_nettype wire

//--- dv/resource_map_decoder_bench.sv
// Self-checking bench for the resource map decoder.
`timescale 1ns/100ps
`default_nettype none
module resource_map_decoder_bench;
	import rmd_pkg::*;
	typedef struct packed {
		logic [15:0] a;
		logic w16;
		logic wr;
		rmd_sel_e sel;
		logic [4:0] bits;
	} rmd_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] mode_pins;
	logic cpu_req, cpu_write, cpu_wide, bdm_active, wait_mode;
	logic [15:0] cpu_addr;
	rmd_sel_e res_sel, s_sel;
	logic follow_region, port_e_local, nvm_read_ok, ext_cycle, low_byte_strobe, ext_rw, ext_a0;
	logic byte_swap, eclk, bus_busy, ext_bus_on, map_iface_on, bus_narrow;
	logic [5:0] s_bits;
	int n_fail, n_checks, hi_len, n_ext, n0, k;
	rmd_row_s rows [6];
	logic [7:0] ra [5] = '{ADDR_MODE, ADDR_RAMBASE, ADDR_REGBASE, ADDR_NVMBASE, ADDR_MISC};
	logic [7:0] rv [5] = '{8'hF0, 8'h08, 8'h00, 8'h01, 8'h0C};

	rmd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_pins(mode_pins), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
		.cpu_write(cpu_write), .cpu_wide(cpu_wide), .bdm_active(bdm_active),
		.wait_mode(wait_mode), .res_sel(res_sel), .follow_region(follow_region),
		.port_e_local(port_e_local), .nvm_read_ok(nvm_read_ok), .ext_cycle(ext_cycle),
		.low_byte_strobe(low_byte_strobe), .ext_rw(ext_rw), .ext_a0(ext_a0),
		.byte_swap(byte_swap), .bus_narrow(bus_narrow), .eclk(eclk), .bus_busy(bus_busy),
		.ext_bus_on(ext_bus_on), .map_iface_on(map_iface_on));
	rmd_ext_model u_far (.pclk(pclk), .presetn(presetn), .eclk(eclk), .bus_busy(bus_busy),
		.hi_len(hi_len), .n_ext(n_ext));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic summarize();
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			summarize();
		end
		rd = prdata;
		s_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The wait after each access lets the longest stretch finish before the next one.
	task automatic acc(input logic [15:0] a, input logic w16, input logic wr);
		@(posedge pclk);
		cpu_req <= 1'b1;
		cpu_addr <= a;
		cpu_wide <= w16;
		cpu_write <= wr;
		n0 = n_ext;
		@(posedge pclk);
		cpu_req <= 1'b0;
		#1;
		s_sel = res_sel;
		s_bits = {low_byte_strobe, ext_rw, ext_a0, byte_swap, follow_region, ext_cycle};
		repeat (10) @(posedge pclk);
	endtask

	task automatic do_reset(input logic [2:0] m);
		presetn <= 1'b0;
		mode_pins <= m;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask

	initial begin
		{psel, penable, pwrite, cpu_req, cpu_write, cpu_wide, bdm_active, wait_mode} = '0;
		paddr = '0;
		pwdata = '0;
		cpu_addr = '0;
		n_fail = 0;
		n_checks = 0;
		presetn = 1'b0;
		mode_pins = 3'h7;
		rows = '{'{16'h0010, 1'b0, 1'b0, SEL_REG, 5'b11000}, '{16'h0801, 1'b1, 1'b0, SEL_RAM, 5'b11110},
			'{16'h0D02, 1'b1, 1'b1, SEL_NVM, 5'b00000}, '{16'h4001, 1'b1, 1'b0, SEL_EXT, 5'b01100},
			'{16'h0201, 1'b0, 1'b1, SEL_EXT, 5'b00101}, '{16'h0C00, 1'b0, 1'b0, SEL_EXT, 5'b11000}};
		do_reset(3'h7);
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			check(rd, {24'h0, rv[i]});
		end
		check(nvm_read_ok, 1'b1);
		check(port_e_local, 1'b1);
		foreach (rows[i]) begin
			acc(rows[i].a, rows[i].w16, rows[i].wr);
			check(s_sel, rows[i].sel);
			check(s_bits, {rows[i].bits, rows[i].sel == SEL_EXT});
			check(n_ext - n0, rows[i].sel == SEL_EXT);
			if (rows[i].sel == SEL_EXT) check(hi_len, rows[i].bits[0] ? 1 : 7);
		end
		apb(1'b0, 8'hFC, 32'h0);
		check(s_err, 1'b1);
		check(rd, 32'h0);
		apb(1'b1, ADDR_REGBASE, 32'h10);
		apb(1'b1, ADDR_REGBASE, 32'h19);
		apb(1'b0, ADDR_REGBASE, 32'h0);
		check(rd, 32'h11);
		acc(16'h1005, 1'b0, 1'b0);
		check(s_sel, SEL_REG);
		acc(16'h1201, 1'b0, 1'b0);
		check({s_sel, s_bits[1]}, {SEL_EXT, 1'b1});
		acc(16'h0010, 1'b0, 1'b0);
		check(s_sel, SEL_EXT);
		apb(1'b1, ADDR_MISC, 32'h0F);
		acc(16'h8000, 1'b1, 1'b0);
		check(s_sel, SEL_ROM);
		acc(16'h7000, 1'b1, 1'b0);
		check(s_sel, SEL_EXT);
		apb(1'b1, ADDR_MODE, 32'h04);
		wait_mode <= 1'b1;
		for (k = 0; k < 30 && (ext_bus_on !== 1'b0 || map_iface_on !== 1'b0); k++) begin
			@(posedge pclk);
		end
		check({ext_bus_on, map_iface_on}, 2'b00);
		if (k == 30) summarize();
		acc(16'h0801, 1'b1, 1'b0);
		check(s_sel, SEL_NONE);
		wait_mode <= 1'b0;
		repeat (8) @(posedge pclk);
		do_reset(3'h3);
		check(port_e_local, 1'b0);
		apb(1'b1, ADDR_MODE, 32'h04);
		apb(1'b0, ADDR_MODE, 32'h0);
		check(rd, 32'h79);
		apb(1'b1, ADDR_MODE, 32'h04);
		apb(1'b0, ADDR_MODE, 32'h0);
		check(rd, 32'h70);
		check(port_e_local, 1'b1);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_MISC, 32'(c * 16 + (3 - c) * 4));
			acc(16'h4000, 1'b1, 1'b0);
			check(hi_len, 7 - 2 * c);
			check(n_ext - n0, 1);
			acc(16'h0200, 1'b1, 1'b0);
			check(hi_len, 1 + 2 * c);
			check(n_ext - n0, 1);
		end
		apb(1'b1, ADDR_MISC, 32'h40);
		acc(16'h0200, 1'b0, 1'b0);
		check(bus_narrow, 1'b1);
		acc(16'h4000, 1'b0, 1'b0);
		check(bus_narrow, 1'b0);
		bdm_active <= 1'b1;
		acc(16'hFF00, 1'b0, 1'b0);
		check(s_sel, SEL_BDM);
		summarize();
	end
endmodule
`default_nettype wire
